// >>> logic/ghl_defines.svh
`ifndef GHL_DEFINES_SVH
`define GHL_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GHL_OFS_CTRL 8'h00
`define GHL_OFS_STAT 8'h04
`define GHL_OFS_CFG 8'h08
`define GHL_OFS_ERR 8'h0c
`define GHL_OFS_SML 8'h10
`define GHL_OFS_RXBUF 8'h14
`define GHL_OFS_FIFO 8'h18
`define GHL_OFS_PWR 8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GHL_CTRL_SPD 1:0
`define GHL_CTRL_FDX 2
`define GHL_CTRL_RSS 3
`define GHL_CTRL_SWRST 4
`define GHL_CFG_D3 0
`define GHL_CFG_SERR 1
`define GHL_CFG_UNSUPPORTED_REQUEST_REPORT_ENABLE 2
`define GHL_ERR_URD 0
`define GHL_PWR_PD 0
`define GHL_PWR_KEEP 1
`define GHL_PWR_WAKE 2
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define GHL_SML_RST 2'h0
`define GHL_RXBUF_RST 15'h0800
`define GHL_BUF_MIN 15'h0100
`define GHL_BUF_MAX 15'h4000
`define GHL_FIFO_RST_KB 6'h10
`define GHL_FIFO_MIN_KB 15'h0001
`define GHL_FIFO_MAX_KB 15'h001f
`define GHL_PKT_BUF_KB 6'h20
`define GHL_JUMBO_MAX 14'h233a
`define GHL_REQ_MAX 15'h0080
`define GHL_PAGE 13'h1000
// ----------------------------------------
// Timing
// ----------------------------------------
`define GHL_REF_KHZ 40000
`define GHL_SML_KHZ_SLOW 100
`define GHL_SML_KHZ_FAST 400
`define GHL_SML_KHZ_PLUS 1000
`endif

// >>> logic/ghl_host_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "ghl_defines.svh"
// Summary of operation
// - Outgoing memory requests are split so none crosses a 4 KB page.
// - Each outgoing request carries at most 128 bytes; reads stay within a 128-byte line.
// - Writes may start anywhere and cross 128-byte lines; reads may not.
// - Configuration requests get retry status until the NVM load completes.
// - Programming-model violations are dropped; non-posted ones complete with abort.
// - Posted violations pulse system error only when both enables are set.
// - Unsupported requests are dropped; non-posted ones complete with unsupported status.
// - Unsupported requests set the detected flag and may pulse system error.
// - Only D0 and D3; in D3 only configuration accesses are accepted.
// - Full duplex at all speeds; half duplex only at 10 and 100.
// - Gigabit speed only while the system is in S0.
// - In sleep states traffic uses only the low-speed management link.
// - Management link clock selects exactly one of 100k, 400k, 1 MHz.
// - The PHY port transmitter runs at the half rate when the NVM port enable bit is set.
// - PHY port setup comes from NVM; no presence detection.
// - Bus master addressing is 64 bits wide.
// - Receive buffer size is programmable from 256 bytes to 16 KB.
// - Receive and transmit FIFO split is programmable in 1 KB steps.
// - Frames up to 9018 bytes accepted within a 32 KB packet buffer.
// - Software reset clears the operating registers and idles the request splitter; the configuration space and clock divider are kept.
// - Receive scaling spreads frames over two receive queues.
// - Unless statically disabled, sleep output stays high in Deep Sx to keep the PHY powered.
// - PHY power control goes low only while sleep output is high.
// - Sleep output low when statically disabled, otherwise always high in S0.
module ghl_host_link #(
  parameter int AW = 64,
  parameter int LW = 15
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_req_valid,
  input wire ghl_pkg::ghl_kind_e rx_req_kind,
  input wire logic rx_req_posted,
  input wire logic rx_req_unsup,
  input wire logic rx_req_violation,
  input wire logic [7:0] rx_req_tag,
  output logic cpl_valid,
  output ghl_pkg::ghl_cpl_e cpl_status,
  output logic [7:0] cpl_tag,
  output logic rx_req_accept,
  output logic serr_pulse,
  input wire logic dma_req_valid,
  input wire logic [AW-1:0] dma_req_addr,
  input wire logic [LW-1:0] dma_req_len,
  input wire logic dma_req_write,
  output logic dma_req_ready,
  output logic bus_req_valid,
  output logic [AW-1:0] bus_req_addr,
  output logic [7:0] bus_req_len,
  output logic bus_req_write,
  output logic bus_req_last,
  input wire logic bus_req_ready,
  input wire logic nvm_load_done,
  input wire logic nvm_port_en,
  input wire logic [3:0] nvm_port_num,
  output logic [3:0] phy_port_num,
  output logic phy_port_half_rate,
  input wire ghl_pkg::ghl_sys_e sys_state,
  input wire logic gbe_disable_strap,
  input wire logic phy_wake_request_n,
  output logic host_wake,
  output logic lan_subsystem_sleep_n,
  output logic phy_power_control_out,
  output ghl_pkg::ghl_speed_e mac_speed,
  output logic mac_full_duplex,
  output logic use_mgmt_link,
  output logic low_speed_management_link_clk,
  input wire logic rx_hash_valid,
  input wire logic rx_hash_bit,
  output logic rx_queue_valid,
  output logic rx_queue,
  input wire logic rx_frame_done,
  input wire logic [13:0] rx_frame_len,
  output logic rx_frame_oversize,
  output logic [14:0] rx_buf_size,
  output logic [5:0] rx_fifo_kb,
  output logic [5:0] tx_fifo_kb
);
  function automatic logic [14:0] ghl_clamp(input logic [14:0] v, input logic [14:0] lo, input logic [14:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : ghl_clamp
  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire logic wr_ctrl = reg_wr && (reg_addr == `GHL_OFS_CTRL);
  wire logic wr_cfg = reg_wr && (reg_addr == `GHL_OFS_CFG);
  wire logic wr_err = reg_wr && (reg_addr == `GHL_OFS_ERR);
  wire logic wr_sml = reg_wr && (reg_addr == `GHL_OFS_SML);
  wire logic wr_rxbuf = reg_wr && (reg_addr == `GHL_OFS_RXBUF);
  wire logic wr_fifo = reg_wr && (reg_addr == `GHL_OFS_FIFO);
  wire logic wr_pwr = reg_wr && (reg_addr == `GHL_OFS_PWR);
  logic soft_rst_q;
  logic [1:0] spd_q;
  logic fdx_q;
  logic rss_en_q;
  logic [1:0] sml_rate_q;
  logic pd_q;
  logic keep_q;
  logic wake_en_q;
  logic d3_q;
  logic serr_en_q;
  logic unsupported_request_report_enable_en_q;
  logic urd_q;
  logic nvm_seen_q;
  // Illegal speed or rate codes are ignored so the previous setting holds
  wire logic spd_ok = (reg_wdata[`GHL_CTRL_SPD] != 2'h3);
  wire logic sml_ok = (reg_wdata[1:0] != 2'h3);
  wire logic [14:0] rxbuf_d = ghl_clamp(reg_wdata[14:0], `GHL_BUF_MIN, `GHL_BUF_MAX);
  wire logic [5:0] fifo_d = 6'(ghl_clamp(15'(reg_wdata[5:0]), `GHL_FIFO_MIN_KB, `GHL_FIFO_MAX_KB));
  // Retry outranks the other statuses until the NVM load ends
  wire logic is_cfg = (rx_req_kind == ghl_pkg::GHL_K_CFG);
  wire logic crs = is_cfg && !nvm_load_done;
  wire logic ur = !crs && (rx_req_unsup || (d3_q && !is_cfg));
  wire logic ca = !crs && !ur && rx_req_violation;
  // ----------------------------------------
  // Operating state, cleared by software reset
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctrl && reg_wdata[`GHL_CTRL_SWRST];
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst || soft_rst_q) begin
      spd_q <= 2'h2;
      fdx_q <= 1'b1;
      rss_en_q <= 1'b0;
      sml_rate_q <= `GHL_SML_RST;
      rx_buf_size <= `GHL_RXBUF_RST;
      rx_fifo_kb <= `GHL_FIFO_RST_KB;
      pd_q <= 1'b0;
      keep_q <= 1'b0;
      wake_en_q <= 1'b0;
    end else begin
      if (wr_ctrl && spd_ok) spd_q <= reg_wdata[`GHL_CTRL_SPD];
      if (wr_ctrl) fdx_q <= reg_wdata[`GHL_CTRL_FDX];
      if (wr_ctrl) rss_en_q <= reg_wdata[`GHL_CTRL_RSS];
      if (wr_sml && sml_ok) sml_rate_q <= reg_wdata[1:0];
      if (wr_rxbuf) rx_buf_size <= rxbuf_d;
      if (wr_fifo) rx_fifo_kb <= fifo_d;
      if (wr_pwr) pd_q <= reg_wdata[`GHL_PWR_PD];
      if (wr_pwr) keep_q <= reg_wdata[`GHL_PWR_KEEP];
      if (wr_pwr) wake_en_q <= reg_wdata[`GHL_PWR_WAKE];
    end
  end
  // ----------------------------------------
  // Configuration space, kept over software reset
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      d3_q <= 1'b0;
      serr_en_q <= 1'b0;
      unsupported_request_report_enable_en_q <= 1'b0;
      urd_q <= 1'b0;
      nvm_seen_q <= 1'b0;
      phy_port_num <= 4'h0;
      phy_port_half_rate <= 1'b0;
    end else begin
      if (wr_cfg) d3_q <= reg_wdata[`GHL_CFG_D3];
      if (wr_cfg) serr_en_q <= reg_wdata[`GHL_CFG_SERR];
      if (wr_cfg) unsupported_request_report_enable_en_q <= reg_wdata[`GHL_CFG_UNSUPPORTED_REQUEST_REPORT_ENABLE];
      // Set wins over a write-one-to-clear in the same cycle
      urd_q <= (urd_q && !(wr_err && reg_wdata[`GHL_ERR_URD])) || (rx_req_valid && ur);
      nvm_seen_q <= nvm_load_done;
      // Port setup is taken from the NVM image once; nothing probes the PHY
      if (nvm_load_done && !nvm_seen_q) begin
        phy_port_num <= nvm_port_num;
        phy_port_half_rate <= nvm_port_en;
      end
    end
  end
  // ----------------------------------------
  // Inbound request screening
  // ----------------------------------------
  wire ghl_pkg::ghl_cpl_e status_d = crs ? ghl_pkg::GHL_CPL_CRS : ur ? ghl_pkg::GHL_CPL_UR :
    ca ? ghl_pkg::GHL_CPL_CA : ghl_pkg::GHL_CPL_SC;
  wire logic serr_d = rx_req_valid && serr_en_q && unsupported_request_report_enable_en_q && (ur || (ca && rx_req_posted));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpl_valid <= 1'b0;
      cpl_status <= ghl_pkg::GHL_CPL_SC;
      cpl_tag <= 8'h00;
      rx_req_accept <= 1'b0;
      serr_pulse <= 1'b0;
    end else begin
      cpl_valid <= rx_req_valid && !rx_req_posted;
      cpl_status <= status_d;
      cpl_tag <= rx_req_tag;
      rx_req_accept <= rx_req_valid && !crs && !ur && !ca;
      serr_pulse <= serr_d;
    end
  end
  // ----------------------------------------
  // Link mode and power pins
  // ----------------------------------------
  wire logic in_s0 = (sys_state == ghl_pkg::GHL_ST_S0);
  wire logic in_deep = (sys_state == ghl_pkg::GHL_ST_DEEPSX);
  wire ghl_pkg::ghl_speed_e speed_d = (spd_q == 2'h2 && !in_s0) ? ghl_pkg::GHL_SPD_100 :
    ghl_pkg::ghl_speed_e'(spd_q);
  wire logic fdx_d = (speed_d == ghl_pkg::GHL_SPD_1000) || fdx_q;
  // A strapped-off controller releases the PHY even in S0
  wire logic sleep_n_d = !gbe_disable_strap && (in_s0 || in_deep || keep_q);
  wire logic phypc_d = sleep_n_d ? !pd_q : 1'b1;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mac_speed <= ghl_pkg::GHL_SPD_10;
      mac_full_duplex <= 1'b1;
      use_mgmt_link <= 1'b1;
      lan_subsystem_sleep_n <= 1'b0;
      phy_power_control_out <= 1'b1;
      host_wake <= 1'b0;
    end else begin
      mac_speed <= speed_d;
      mac_full_duplex <= fdx_d;
      use_mgmt_link <= !in_s0;
      lan_subsystem_sleep_n <= sleep_n_d;
      phy_power_control_out <= phypc_d;
      host_wake <= !phy_wake_request_n && !in_s0 && wake_en_q;
    end
  end
  // ----------------------------------------
  // Receive side helpers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_queue_valid <= 1'b0;
      rx_queue <= 1'b0;
      rx_frame_oversize <= 1'b0;
      tx_fifo_kb <= `GHL_PKT_BUF_KB - `GHL_FIFO_RST_KB;
    end else begin
      rx_queue_valid <= rx_hash_valid;
      rx_queue <= rss_en_q && rx_hash_bit;
      rx_frame_oversize <= rx_frame_done && (rx_frame_len > `GHL_JUMBO_MAX);
      tx_fifo_kb <= `GHL_PKT_BUF_KB - rx_fifo_kb;
    end
  end
  // ----------------------------------------
  // Read back
  // ----------------------------------------
  wire logic [31:0] rd_mux =
    (reg_addr == `GHL_OFS_CTRL) ? {28'h0, rss_en_q, fdx_q, spd_q} :
    (reg_addr == `GHL_OFS_STAT) ? {27'h0, nvm_seen_q, use_mgmt_link, mac_full_duplex, mac_speed} :
    (reg_addr == `GHL_OFS_CFG) ? {29'h0, unsupported_request_report_enable_en_q, serr_en_q, d3_q} :
    (reg_addr == `GHL_OFS_ERR) ? {31'h0, urd_q} :
    (reg_addr == `GHL_OFS_SML) ? {30'h0, sml_rate_q} :
    (reg_addr == `GHL_OFS_RXBUF) ? {17'h0, rx_buf_size} :
    (reg_addr == `GHL_OFS_FIFO) ? {20'h0, tx_fifo_kb, rx_fifo_kb} :
    (reg_addr == `GHL_OFS_PWR) ? {29'h0, wake_en_q, keep_q, pd_q} : 32'h0;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end
  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  // Bus mastering is held off outside D0
  ghl_req_splitter #(.AW(AW), .LW(LW)) u_split (
    .ref_clk(ref_clk),
    .rst(rst),
    .srst(soft_rst_q),
    .req_valid(dma_req_valid && !d3_q),
    .req_addr(dma_req_addr),
    .req_len(dma_req_len),
    .req_write(dma_req_write),
    .req_ready(dma_req_ready),
    .chunk_valid(bus_req_valid),
    .chunk_addr(bus_req_addr),
    .chunk_len(bus_req_len),
    .chunk_write(bus_req_write),
    .chunk_last(bus_req_last),
    .chunk_ready(bus_req_ready)
  );
  ghl_mgmt_clk_div u_sml_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .rate_sel(sml_rate_q),
    .mgmt_clk(low_speed_management_link_clk)
  );
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cfg_retry_crs: assert property (@(posedge ref_clk) disable iff (rst)
    rx_req_valid && is_cfg && !nvm_load_done && !rx_req_posted |=> cpl_valid && cpl_status == ghl_pkg::GHL_CPL_CRS)
    else $error("config request not retried during NVM load");
  a_abort_status: assert property (@(posedge ref_clk) disable iff (rst)
    rx_req_valid && !rx_req_posted && rx_req_violation && !rx_req_unsup && !is_cfg && !d3_q
    |=> cpl_valid && cpl_status == ghl_pkg::GHL_CPL_CA && !rx_req_accept)
    else $error("violation not completed with abort");
  a_serr_gating: assert property (@(posedge ref_clk) disable iff (rst)
    serr_pulse |-> $past(serr_en_q) && $past(unsupported_request_report_enable_en_q))
    else $error("system error without both enables");
  a_ur_status: assert property (@(posedge ref_clk) disable iff (rst)
    rx_req_valid && !rx_req_posted && rx_req_unsup && !is_cfg |=> cpl_status == ghl_pkg::GHL_CPL_UR)
    else $error("unsupported request not completed with UR");
  a_urd_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    rx_req_valid && rx_req_unsup && !is_cfg |=> urd_q)
    else $error("unsupported request flag not set");
  a_d3_no_accept: assert property (@(posedge ref_clk) disable iff (rst)
    rx_req_valid && d3_q && !is_cfg |=> !rx_req_accept)
    else $error("non-config request accepted in D3");
  a_gig_full_duplex: assert property (@(posedge ref_clk) disable iff (rst)
    mac_speed == ghl_pkg::GHL_SPD_1000 |-> mac_full_duplex)
    else $error("half duplex at gigabit");
  a_gig_only_s0: assert property (@(posedge ref_clk) disable iff (rst)
    mac_speed == ghl_pkg::GHL_SPD_1000 |-> $past(sys_state) == ghl_pkg::GHL_ST_S0 && !use_mgmt_link)
    else $error("gigabit outside S0");
  a_deep_sx_power: assert property (@(posedge ref_clk) disable iff (rst)
    in_deep && !gbe_disable_strap |=> lan_subsystem_sleep_n)
    else $error("PHY unpowered in Deep Sx");
  a_phy_pc_order: assert property (@(posedge ref_clk) disable iff (rst)
    !phy_power_control_out |-> lan_subsystem_sleep_n)
    else $error("PHY power control low while sleep asserted");
  a_sml_rate_legal: assert property (@(posedge ref_clk) disable iff (rst)
    sml_rate_q != 2'h3)
    else $error("illegal management link rate");
  a_rss_queue_map: assert property (@(posedge ref_clk) disable iff (rst)
    rx_hash_valid && rss_en_q
    |=> rx_queue_valid && rx_queue == $past(rx_hash_bit))
    else $error("receive queue not taken from hash");
  c_cfg_retry: cover property (@(posedge ref_clk) disable iff (rst)
    cpl_valid && cpl_status == ghl_pkg::GHL_CPL_CRS);
  c_ur_with_serr: cover property (@(posedge ref_clk) disable iff (rst)
    cpl_valid && cpl_status == ghl_pkg::GHL_CPL_UR && serr_pulse);
  c_deep_sx_wake: cover property (@(posedge ref_clk) disable iff (rst)
    in_deep && lan_subsystem_sleep_n ##1 host_wake);
endmodule : ghl_host_link
`default_nettype wire

// >>> logic/ghl_mgmt_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
`include "ghl_defines.svh"
module ghl_mgmt_clk_div (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] rate_sel,
  output logic mgmt_clk
);
  localparam logic [7:0] HALF_SLOW = 8'(`GHL_REF_KHZ / (2 * `GHL_SML_KHZ_SLOW));
  localparam logic [7:0] HALF_FAST = 8'(`GHL_REF_KHZ / (2 * `GHL_SML_KHZ_FAST));
  localparam logic [7:0] HALF_PLUS = 8'(`GHL_REF_KHZ / (2 * `GHL_SML_KHZ_PLUS));
  logic [7:0] cnt_q;
  wire logic [7:0] half = (rate_sel == 2'h2) ? HALF_PLUS : (rate_sel == 2'h1) ? HALF_FAST : HALF_SLOW;
  // Compare with >= so a rate change to a shorter period never overruns
  wire logic wrap = (cnt_q >= half - 8'h01);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      mgmt_clk <= 1'b1;
    end else begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      mgmt_clk <= wrap ? ~mgmt_clk : mgmt_clk;
    end
  end
endmodule : ghl_mgmt_clk_div
`default_nettype wire

// >>> logic/ghl_pkg.sv
`default_nettype none
package ghl_pkg;
  typedef enum logic [1:0] {GHL_K_CFG, GHL_K_MEM, GHL_K_IO, GHL_K_MSG} ghl_kind_e;
  typedef enum logic [1:0] {GHL_CPL_SC, GHL_CPL_UR, GHL_CPL_CRS, GHL_CPL_CA} ghl_cpl_e;
  typedef enum logic [1:0] {GHL_ST_S0, GHL_ST_SX, GHL_ST_DEEPSX} ghl_sys_e;
  typedef enum logic [1:0] {GHL_SPD_10, GHL_SPD_100, GHL_SPD_1000} ghl_speed_e;
  typedef enum logic {GHL_SPLIT_IDLE, GHL_SPLIT_BUSY} ghl_split_e;
endpackage : ghl_pkg
`default_nettype wire

// >>> logic/ghl_req_splitter.sv
`timescale 1ns/100ps
`default_nettype none
`include "ghl_defines.svh"
module ghl_req_splitter #(
  parameter int AW = 64,
  parameter int LW = 15
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic [AW-1:0] req_addr,
  input wire logic [LW-1:0] req_len,
  input wire logic req_write,
  output logic req_ready,
  output logic chunk_valid,
  output logic [AW-1:0] chunk_addr,
  output logic [7:0] chunk_len,
  output logic chunk_write,
  output logic chunk_last,
  input wire logic chunk_ready
);
  function automatic logic [LW-1:0] ghl_min(input logic [LW-1:0] a, input logic [LW-1:0] b);
    return (a < b) ? a : b;
  endfunction : ghl_min
  ghl_pkg::ghl_split_e state_q;
  logic [AW-1:0] addr_q;
  logic [LW-1:0] rem_q;
  logic wr_q;
  // Writes may cross 128-byte lines; reads stop at the next 128-byte line
  wire logic [LW-1:0] bound = wr_q ? `GHL_REQ_MAX : `GHL_REQ_MAX - LW'(addr_q[6:0]);
  wire logic [LW-1:0] to_page = LW'(`GHL_PAGE - {1'b0, addr_q[11:0]});
  wire logic [LW-1:0] len = ghl_min(rem_q, ghl_min(bound, to_page));
  wire logic emit = (state_q == ghl_pkg::GHL_SPLIT_BUSY) && (!chunk_valid || chunk_ready);
  wire logic load = (state_q == ghl_pkg::GHL_SPLIT_IDLE) && req_valid && (req_len != '0);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ghl_pkg::GHL_SPLIT_IDLE;
      req_ready <= 1'b1;
      chunk_valid <= 1'b0;
      addr_q <= '0;
      rem_q <= '0;
      wr_q <= 1'b0;
      chunk_addr <= '0;
      chunk_len <= 8'h00;
      chunk_write <= 1'b0;
      chunk_last <= 1'b0;
    end else if (srst) begin
      state_q <= ghl_pkg::GHL_SPLIT_IDLE;
      req_ready <= 1'b1;
      chunk_valid <= 1'b0;
    end else begin
      if (load) begin
        state_q <= ghl_pkg::GHL_SPLIT_BUSY;
        req_ready <= 1'b0;
        addr_q <= req_addr;
        rem_q <= req_len;
        wr_q <= req_write;
      end
      if (emit) begin
        chunk_valid <= 1'b1;
        chunk_addr <= addr_q;
        chunk_len <= len[7:0];
        chunk_write <= wr_q;
        chunk_last <= (rem_q == len);
        addr_q <= addr_q + AW'(len);
        rem_q <= rem_q - len;
        if (rem_q == len) begin
          state_q <= ghl_pkg::GHL_SPLIT_IDLE;
          req_ready <= 1'b1;
        end
      end else if (chunk_ready) begin
        chunk_valid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_chunk_page_cross: assert property (@(posedge ref_clk) disable iff (rst)
    chunk_valid |-> ({1'b0, chunk_addr[11:0]} + 13'(chunk_len)) <= `GHL_PAGE)
    else $error("chunk crosses 4 KB page");
  a_chunk_size_max: assert property (@(posedge ref_clk) disable iff (rst)
    chunk_valid |-> (chunk_len != 8'h00) && (chunk_len <= 8'h80))
    else $error("chunk length out of range");
  a_read_line_align: assert property (@(posedge ref_clk) disable iff (rst)
    chunk_valid && !chunk_write |-> ({1'b0, chunk_addr[6:0]} + chunk_len) <= 8'h80)
    else $error("read chunk crosses 128-byte line");
  c_split_multi: cover property (@(posedge ref_clk) disable iff (rst)
    chunk_valid && chunk_ready && !chunk_last ##1 chunk_valid && chunk_last);
endmodule : ghl_req_splitter
`default_nettype wire

// >>> sim/ghl_host_link_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ghl_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t mismatch %0h/%0h", $time, g, e); end end
module ghl_host_link_tb_top;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_req_valid = 0, rx_req_posted = 0, rx_req_unsup = 0;
  logic rx_req_violation = 0, dma_req_valid = 0, dma_req_write = 0, nvm_load_done = 0, gbe_disable_strap = 0;
  logic rx_frame_done = 0, stall = 0, cpl_valid, serr_pulse, dma_req_ready, bus_req_valid, bus_req_ready;
  logic lan_subsystem_sleep_n, phy_power_control_out, mac_full_duplex, use_mgmt_link, mgmt_clk, phy_port_half_rate;
  logic rx_frame_oversize, rx_queue;
  logic [3:0] phy_port_num;
  logic [7:0] reg_addr = 8'h00, bus_req_len;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [63:0] dma_req_addr = 64'h0, bus_req_addr;
  logic [14:0] dma_req_len = 15'h0;
  logic [13:0] rx_frame_len = 14'h0;
  logic [5:0] tx_fifo_kb;
  ghl_pkg::ghl_kind_e rx_req_kind = ghl_pkg::GHL_K_CFG;
  ghl_pkg::ghl_sys_e sys_state = ghl_pkg::GHL_ST_S0;
  ghl_pkg::ghl_cpl_e cpl_status;
  ghl_pkg::ghl_speed_e mac_speed;
  int err_total = 0, samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  ghl_host_link i_ghl_host_link (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_req_valid,
    .rx_req_kind, .rx_req_posted, .rx_req_unsup, .rx_req_violation, .rx_req_tag(reg_addr), .cpl_valid, .cpl_status,
    .cpl_tag(), .rx_req_accept(), .serr_pulse, .dma_req_valid, .dma_req_addr, .dma_req_len, .dma_req_write,
    .dma_req_ready, .bus_req_valid, .bus_req_addr, .bus_req_len, .bus_req_write(), .bus_req_last(), .bus_req_ready,
    .nvm_load_done, .nvm_port_en(1'h1), .nvm_port_num(4'h5), .phy_port_num, .phy_port_half_rate, .sys_state,
    .gbe_disable_strap, .phy_wake_request_n(1'h1), .host_wake(), .lan_subsystem_sleep_n, .phy_power_control_out,
    .mac_speed, .mac_full_duplex, .use_mgmt_link, .low_speed_management_link_clk(mgmt_clk),
    .rx_hash_valid(rx_frame_done), .rx_hash_bit(rx_frame_len[0]), .rx_queue_valid(), .rx_queue,
    .rx_frame_done, .rx_frame_len, .rx_frame_oversize, .rx_buf_size(), .rx_fifo_kb(), .tx_fifo_kb);
  ghl_host_mem_model i_ghl_host_mem_model (.ref_clk, .rst, .stall, .bus_req_valid, .bus_req_addr, .bus_req_len,
    .bus_req_ready);
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    cyc(1);
    reg_rd <= 0;
    `CHK(reg_rdata, e)
  endtask : rdc
  // Kind 0 cfg, 1 mem; status 0 ok, 1 unsupported, 2 retry, 3 abort
  task automatic req(input logic [1:0] k, input logic p, u, v, ec, input logic [1:0] es, input logic ep);
    @(posedge ref_clk);
    {rx_req_valid, rx_req_posted, rx_req_unsup, rx_req_violation} <= {1'h1, p, u, v};
    rx_req_kind <= ghl_pkg::ghl_kind_e'(k);
    cyc(1);
    rx_req_valid <= 0;
    `CHK({cpl_valid, serr_pulse, ec ? cpl_status : 2'h0}, {ec, ep, es})
  endtask : req
  task automatic dma(input logic [63:0] a, input int len, input logic w);
    logic [63:0] p;
    int r, l, i;
    i = i_ghl_host_mem_model.n;
    @(posedge ref_clk);
    {dma_req_valid, dma_req_write, dma_req_addr, dma_req_len} <= {1'h1, w, a, len[14:0]};
    cyc(1);
    dma_req_valid <= 0;
    for (l = 0; l < 60 && dma_req_ready !== 1; l++) cyc(1);
    cyc(6);
    p = a;
    r = len;
    while (r > 0) begin
      l = 4096 - int'(p[11:0]);
      if (!w && 128 - int'(p[6:0]) < l) l = 128 - int'(p[6:0]);
      l = (l > 128) ? 128 : l;
      l = (r < l) ? r : l;
      `CHK(i_ghl_host_mem_model.got_len[i], l[7:0])
      `CHK(i_ghl_host_mem_model.got_addr[i], p)
      p += l;
      r -= l;
      i++;
    end
    `CHK(i_ghl_host_mem_model.n, i)
  endtask : dma
  task automatic pw(input ghl_pkg::ghl_sys_e s, input logic st, input logic [3:0] e);
    @(posedge ref_clk);
    sys_state <= s;
    gbe_disable_strap <= st;
    cyc(3);
    `CHK({lan_subsystem_sleep_n, phy_power_control_out, use_mgmt_link, mac_speed == ghl_pkg::GHL_SPD_1000}, e)
  endtask : pw
  task automatic t_regs;
    rdc(`GHL_OFS_CTRL, 32'h6);
    rdc(8'h40, 32'h0);
    wr(`GHL_OFS_RXBUF, 32'h10);
    rdc(`GHL_OFS_RXBUF, 32'h100);
    wr(`GHL_OFS_RXBUF, 32'h7fff);
    rdc(`GHL_OFS_RXBUF, 32'h4000);
    wr(`GHL_OFS_FIFO, 32'h5);
    rdc(`GHL_OFS_FIFO, 32'h6c5);
    wr(`GHL_OFS_CFG, 32'h6);
    wr(`GHL_OFS_CTRL, 32'h10);
    cyc(3);
    rdc(`GHL_OFS_RXBUF, 32'h800);
    rdc(`GHL_OFS_CFG, 32'h6);
    $display("regs done");
  endtask : t_regs
  task automatic t_inb;
    req(0, 0, 0, 0, 1, 2, 0);
    @(posedge ref_clk);
    nvm_load_done <= 1;
    req(1, 0, 1, 0, 1, 1, 1);
    rdc(`GHL_OFS_ERR, 32'h1);
    req(1, 1, 1, 0, 0, 0, 1);
    req(1, 1, 0, 1, 0, 0, 1);
    req(1, 0, 0, 1, 1, 3, 0);
    wr(`GHL_OFS_CFG, 32'h7);
    req(1, 0, 0, 0, 1, 1, 1);
    req(0, 0, 0, 0, 1, 0, 0);
    wr(`GHL_OFS_CFG, 32'h6);
    `CHK(phy_port_half_rate, 1'h1)
    `CHK(phy_port_num, 4'h5)
    $display("inbound done");
  endtask : t_inb
  task automatic t_pwr;
    int k, hp[3] = '{200, 50, 20};
    pw(ghl_pkg::GHL_ST_SX, 0, 4'b0110);
    pw(ghl_pkg::GHL_ST_DEEPSX, 0, 4'b1110);
    pw(ghl_pkg::GHL_ST_S0, 1, 4'b0101);
    wr(`GHL_OFS_PWR, 32'h1);
    pw(ghl_pkg::GHL_ST_S0, 0, 4'b1001);
    wr(`GHL_OFS_CTRL, 32'h0);
    cyc(3);
    `CHK(mac_full_duplex, 1'h0)
    wr(`GHL_OFS_CTRL, 32'h2);
    cyc(3);
    `CHK(mac_full_duplex, 1'h1)
    for (int r = 0; r < 3; r++) begin
      wr(`GHL_OFS_SML, r);
      for (k = 0; k < 500 && mgmt_clk === 0; k++) cyc(1);
      for (k = 0; k < 500 && mgmt_clk === 1; k++) cyc(1);
      for (k = 0; k < 500 && mgmt_clk === 0; k++) cyc(1);
      `CHK(k, hp[r])
    end
    wr(`GHL_OFS_CTRL, 32'ha);
    @(posedge ref_clk);
    {rx_frame_done, rx_frame_len} <= {1'h1, 14'h233b};
    cyc(1);
    rx_frame_done <= 0;
    `CHK(rx_frame_oversize, 1'h1)
    `CHK(rx_queue, 1'h1)
    $display("power done");
  endtask : t_pwr
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    t_regs();
    t_inb();
    dma(64'hfc0, 200, 0);
    stall <= 1;
    dma(64'h1_0000_0ff0, 200, 1);
    t_pwr();
    finish_test();
  end
endmodule : ghl_host_link_tb_top
`default_nettype wire

// >>> sim/ghl_host_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ghl_host_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic bus_req_valid,
  input wire logic [63:0] bus_req_addr,
  input wire logic [7:0] bus_req_len,
  output logic bus_req_ready
);
  // Slow mode takes every other cycle so chunks must be held
  logic slow_q;
  logic [63:0] got_addr [16];
  logic [7:0] got_len [16];
  int n;
  assign bus_req_ready = !stall || slow_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slow_q <= 1'h0;
      n <= 0;
    end else begin
      slow_q <= !slow_q;
      if (bus_req_valid && bus_req_ready) begin
        got_addr[n[3:0]] <= bus_req_addr;
        got_len[n[3:0]] <= bus_req_len;
        n <= n + 1;
      end
    end
  end
endmodule : ghl_host_mem_model
`default_nettype wire
